/* File: logic/ocu_pkg.sv */
// Purpose: Shared constants and types for the octal code update block.
// Assumes: One 200 MHz clock; the serial bus slave lives outside.
// Notes:   Every offset, field, reset value and code is named here once.
package ocu_pkg;

    // ************************************************************
    // Sizes
    // ************************************************************
    localparam int unsigned NUM_CH        = 8;   // Converter channels
    localparam int unsigned CH_W          = 3;   // Channel index width
    localparam int unsigned CODE_W        = 10;  // Wide variant code width
    localparam int unsigned CODE_W_NARROW = 8;   // Narrow variant width
    localparam int unsigned ADDR_W        = 4;   // Register address width
    localparam int unsigned DATA_W        = 16;  // Register write data width

    // ************************************************************
    // Register addresses and fields
    // ************************************************************
    localparam logic [ADDR_W-1:0] PD_ADDR   = 4'h1; // Power-down control
    localparam logic [ADDR_W-1:0] TRIG_ADDR = 4'h2; // Trigger register
    localparam int unsigned CODE_SEL_BIT    = 3;    // Set for channel codes
    localparam int unsigned SRF_LSB         = 0;    // soft_reset_field pos
    localparam int unsigned SRF_W           = 16;   // soft_reset_field width
    localparam logic [SRF_W-1:0] SOFT_RST_CODE = 16'h1010;

    // ************************************************************
    // Reset values and codes
    // ************************************************************
    localparam logic [CODE_W-1:0] CODE_RST    = 10'h000; // Zero code
    localparam logic [CODE_W-1:0] NARROW_MASK = 10'h0ff; // Narrow range
    localparam logic [NUM_CH-1:0] PD_RST      = 8'hff;   // All powered down
    localparam logic              PIN_IDLE    = 1'b1;    // Pins idle high
    localparam logic [7:0] GC_ADDR_BYTE  = 8'h00;        // General call
    localparam logic [7:0] GC_RESET_BYTE = 8'h06;        // Reset command

    // General call detector states
    typedef enum logic [1:0] {
        GC_IDLE,
        GC_STARTED,
        GC_ADDRESSED
    } ocu_gc_state_t;

endpackage : ocu_pkg

/* File: logic/ocu_pin_sync.sv */
// Purpose: Bring an outside pin level into the clock domain.
// Assumes: Pin is asynchronous to clk_i.
// Notes:   Three flops; a change counts once the last two agree.
`timescale 1ns/1ps
`default_nettype none
module ocu_pin_sync (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    // Pin side
    input  wire logic pin_i,
    // Domain side
    output var  logic level_o,
    output var  logic fell_o
);

    logic meta_q;   // First stage, read only by the second
    logic s2_q;     // Second stage
    logic s3_q;     // Third stage

    // ************************************************************
    // Synchroniser chain
    // ************************************************************
    // Shift the pin through three stages
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= ocu_pkg::PIN_IDLE;
            s2_q   <= ocu_pkg::PIN_IDLE;
            s3_q   <= ocu_pkg::PIN_IDLE;
        end else begin
            meta_q <= pin_i;
            s2_q   <= meta_q;
            s3_q   <= s2_q;
        end
    end

    // Accept a new level only when the last two stages agree
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            level_o <= ocu_pkg::PIN_IDLE;
            fell_o  <= 1'b0;
        end else begin
            fell_o <= (s2_q == s3_q) && level_o && !s3_q;
            if (s2_q == s3_q) begin
                level_o <= s3_q;
            end
        end
    end

endmodule : ocu_pin_sync
`default_nettype wire

/* File: logic/ocu_gcall_det.sv */
// Purpose: Spot the general call reset sequence on the serial bus.
// Assumes: The bus slave gives start, stop and received-byte pulses.
// Notes:   byte_vld_i marks the rising edge of the acknowledge bit.
`timescale 1ns/1ps
`default_nettype none
module ocu_gcall_det (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    // Bus events
    input  wire logic       start_i,
    input  wire logic       stop_i,
    input  wire logic       byte_vld_i,
    input  wire logic [7:0] byte_i,
    // Result
    output var  logic       gc_rst_o
);

    ocu_pkg::ocu_gc_state_t state_q;  // Sequence position

    // ************************************************************
    // Sequence tracker
    // ************************************************************
    // Start, address byte, reset byte; anything else starts over
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            state_q  <= ocu_pkg::GC_IDLE;
            gc_rst_o <= 1'b0;
        end else begin
            gc_rst_o <= 1'b0;
            if (start_i) begin
                // Start or repeated start begins a new match
                state_q <= ocu_pkg::GC_STARTED;
            end else if (stop_i) begin
                state_q <= ocu_pkg::GC_IDLE;
            end else if (byte_vld_i) begin
                case (state_q)
                    ocu_pkg::GC_STARTED: begin
                        if (byte_i == ocu_pkg::GC_ADDR_BYTE) begin
                            state_q <= ocu_pkg::GC_ADDRESSED;
                        end else begin
                            state_q <= ocu_pkg::GC_IDLE;
                        end
                    end
                    ocu_pkg::GC_ADDRESSED: begin
                        // Reset fires on the second byte's acknowledge
                        gc_rst_o <= (byte_i == ocu_pkg::GC_RESET_BYTE);
                        state_q  <= ocu_pkg::GC_IDLE;
                    end
                    default: begin
                        state_q <= ocu_pkg::GC_IDLE;
                    end
                endcase
            end
        end
    end

endmodule : ocu_gcall_det
`default_nettype wire

/* File: logic/ocu_update_ctrl.sv */
// Purpose: Buffer and active code registers for eight converter channels.
// Assumes: The serial bus slave sits outside on the same clock.
// Notes:   clear_n_i zeroes the codes at once, without the clock.
`timescale 1ns/1ps
`default_nettype none

// How it works
// - Eight channels, each with own code path
// - Codes are unsigned straight binary
// - Ten or eight bit codes per variant
// - Any reset zeroes buffer and active codes
// - Writes land in the buffer register first
// - Output follows active register changes only
// - Trigger pin level sampled at the write
// - Trigger low: copy at frame end
// - Trigger high: buffer only, output unchanged
// - Trigger pulled low moves pending buffers
// - One trigger edge updates all channels together
// - Clear pin acts without the clock
// - Clear low forces all codes to zero
// - General call 00h then 06h resets
// - Soft reset code in trigger register resets
// - Outputs start powered down until zero written
module ocu_update_ctrl #(
    parameter bit WIDE_VARIANT = 1'b1  // 1: ten-bit codes, 0: eight-bit
) (
    // Clock and reset
    input  wire logic                          clk_i,
    input  wire logic                          rst_n_i,
    // Device pins
    input  wire logic                          load_trigger_n_i,
    input  wire logic                          clear_n_i,
    // Bus framing from the serial slave
    input  wire logic                          start_i,
    input  wire logic                          stop_i,
    input  wire logic                          byte_vld_i,
    input  wire logic [7:0]                    byte_i,
    input  wire logic                          frame_end_i,
    // Register writes from the serial slave
    input  wire logic                          wr_i,
    input  wire logic [ocu_pkg::ADDR_W-1:0]    wr_addr_i,
    input  wire logic [ocu_pkg::DATA_W-1:0]    wr_data_i,
    // Converter side
    output var  logic [ocu_pkg::NUM_CH-1:0][ocu_pkg::CODE_W-1:0] active_code_o,
    output var  logic [ocu_pkg::NUM_CH-1:0][ocu_pkg::CODE_W-1:0] buffer_code_o,
    output var  logic [ocu_pkg::NUM_CH-1:0]    power_down_o,
    output var  logic                          update_o
);

    // ************************************************************
    // Declarations
    // ************************************************************
    typedef logic [ocu_pkg::NUM_CH-1:0][ocu_pkg::CODE_W-1:0] ocu_bank_t;

    logic                          arst_raw_n;  // Reset or clear pin low
    logic                          clr_meta_q;  // Release chain, stage 1
    logic                          int_rst_n;   // Clear-aware reset
    logic                          load_trigger_n_lvl;    // Synchronised trigger level
    logic                          load_trigger_n_fell;   // Trigger falling edge pulse
    logic                          gc_rst;      // General call reset pulse
    logic                          soft_rst;    // Trigger register reset
    logic                          srst;        // Any synchronous reset
    logic                          wr_code;     // Channel code write
    logic                          wr_pd;       // Power-down write
    logic [ocu_pkg::CH_W-1:0]      wr_ch;       // Written channel
    logic [ocu_pkg::CODE_W-1:0]    wr_code_val; // Masked written code
    ocu_bank_t                     buf_q;       // Buffer registers
    ocu_bank_t                     buf_d;       // Buffers incl. this write
    ocu_bank_t                     act_q;       // Active registers
    logic [ocu_pkg::NUM_CH-1:0]    imm_q;       // Immediate copy pending
    logic [ocu_pkg::NUM_CH-1:0]    imm_d;       // Pending incl. this write
    logic [ocu_pkg::NUM_CH-1:0]    pd_q;        // Power-down bits
    logic                          update_q;    // Active bank changed

    // ************************************************************
    // Functions
    // ************************************************************
    // Limit a code to the variant's legal range
    function automatic logic [ocu_pkg::CODE_W-1:0] code_mask(
        input logic [ocu_pkg::CODE_W-1:0] c
    );
        return WIDE_VARIANT ? c : (c & ocu_pkg::NARROW_MASK);
    endfunction : code_mask

    // True when every buffered code lies in the legal range
    function automatic logic bank_legal(input ocu_bank_t b);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < ocu_pkg::NUM_CH; i++) begin
            ok = ok && (b[i] == code_mask(b[i]));
        end
        return ok;
    endfunction : bank_legal

    // ************************************************************
    // Clear pin and reset handling
    // ************************************************************
    assign arst_raw_n = rst_n_i & clear_n_i;

    // Clear asserts at once, releases two edges later
    always_ff @(posedge clk_i or negedge arst_raw_n) begin
        if (!arst_raw_n) begin
            clr_meta_q <= 1'b0;
            int_rst_n  <= 1'b0;
        end else begin
            clr_meta_q <= 1'b1;
            int_rst_n  <= clr_meta_q;
        end
    end

    // Trigger pin into the clock domain
    ocu_pin_sync u_load_trigger_n_sync (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .pin_i   (load_trigger_n_i),
        .level_o (load_trigger_n_lvl),
        .fell_o  (load_trigger_n_fell)
    );

    // General call reset detector
    ocu_gcall_det u_gcall (
        .clk_i      (clk_i),
        .rst_n_i    (rst_n_i),
        .start_i    (start_i),
        .stop_i     (stop_i),
        .byte_vld_i (byte_vld_i),
        .byte_i     (byte_i),
        .gc_rst_o   (gc_rst)
    );

    // ************************************************************
    // Write decode
    // ************************************************************
    assign wr_code = wr_i && wr_addr_i[ocu_pkg::CODE_SEL_BIT];
    assign wr_pd   = wr_i && (wr_addr_i == ocu_pkg::PD_ADDR);
    assign wr_ch   = wr_addr_i[ocu_pkg::CH_W-1:0];
    assign wr_code_val = code_mask(wr_data_i[ocu_pkg::CODE_W-1:0]);
    assign soft_rst = wr_i && (wr_addr_i == ocu_pkg::TRIG_ADDR)
        && (wr_data_i[ocu_pkg::SRF_LSB +: ocu_pkg::SRF_W]
            == ocu_pkg::SOFT_RST_CODE);
    assign srst = soft_rst || gc_rst;

    // Next buffer bank and pending mask, with this cycle's write
    always_comb begin
        buf_d = buf_q;
        imm_d = imm_q;
        if (wr_code) begin
            buf_d[wr_ch] = wr_code_val;
            // Trigger level at the write picks the mode
            if (!load_trigger_n_lvl) begin
                imm_d[wr_ch] = 1'b1;
            end
        end
    end

    // ************************************************************
    // Buffer registers
    // ************************************************************
    // Capture writes; resets and clear force zero code
    always_ff @(posedge clk_i or negedge int_rst_n) begin
        if (!int_rst_n) begin
            buf_q <= {ocu_pkg::NUM_CH{ocu_pkg::CODE_RST}};
        end else if (srst) begin
            buf_q <= {ocu_pkg::NUM_CH{ocu_pkg::CODE_RST}};
        end else begin
            buf_q <= buf_d;
        end
    end

    // Immediate-mode channels waiting for the frame end
    always_ff @(posedge clk_i or negedge int_rst_n) begin
        if (!int_rst_n) begin
            imm_q <= '0;
        end else if (srst || frame_end_i || load_trigger_n_fell) begin
            imm_q <= '0;
        end else begin
            imm_q <= imm_d;
        end
    end

    // ************************************************************
    // Active registers
    // ************************************************************
    // Trigger edge copies all; frame end copies immediate channels
    always_ff @(posedge clk_i or negedge int_rst_n) begin
        if (!int_rst_n) begin
            act_q <= {ocu_pkg::NUM_CH{ocu_pkg::CODE_RST}};
        end else if (srst) begin
            act_q <= {ocu_pkg::NUM_CH{ocu_pkg::CODE_RST}};
        end else if (load_trigger_n_fell) begin
            act_q <= buf_d;
        end else if (frame_end_i) begin
            for (int i = 0; i < ocu_pkg::NUM_CH; i++) begin
                if (imm_d[i]) begin
                    act_q[i] <= buf_d[i];
                end
            end
        end
    end

    // Flag every cycle in which the active bank is reloaded
    always_ff @(posedge clk_i or negedge int_rst_n) begin
        if (!int_rst_n) begin
            update_q <= 1'b0;
        end else begin
            update_q <= !srst && (load_trigger_n_fell || (frame_end_i && |imm_d));
        end
    end

    // ************************************************************
    // Power-down control
    // ************************************************************
    // Outputs start powered down; a zero bit powers a channel up
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pd_q <= ocu_pkg::PD_RST;
        end else if (srst) begin
            pd_q <= ocu_pkg::PD_RST;
        end else if (wr_pd) begin
            pd_q <= wr_data_i[ocu_pkg::NUM_CH-1:0];
        end
    end

    // Outputs straight from the registers
    assign active_code_o = act_q;
    assign buffer_code_o = buf_q;
    assign power_down_o  = pd_q;
    assign update_o      = update_q;

    // ************************************************************
    // Checks
    // ************************************************************
    a_clear_zero: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        !clear_n_i |-> (act_q == '0) && (buf_q == '0))
        else $error("clear low but codes not zero");

    a_clear_holds: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        $rose(clear_n_i) |-> (act_q == '0) ##1 (act_q == '0))
        else $error("codes moved during clear release");

    a_buf_capture: assert property (@(posedge clk_i)
        disable iff (!int_rst_n || !clear_n_i)
        (wr_code && !srst) |=> buf_q[$past(wr_ch)] == $past(wr_code_val))
        else $error("buffer missed a code write");

    a_imm_copy: assert property (@(posedge clk_i)
        disable iff (!int_rst_n || !clear_n_i)
        (wr_code && !load_trigger_n_lvl && !srst && !frame_end_i && !load_trigger_n_fell)
        ##1 (frame_end_i && !wr_code && !srst)
        |=> (act_q[$past(wr_ch, 2)] == $past(wr_code_val, 2)) && update_q)
        else $error("immediate write not applied at frame end");

    a_defer_hold: assert property (@(posedge clk_i)
        disable iff (!int_rst_n || !clear_n_i)
        (wr_code && load_trigger_n_lvl && !load_trigger_n_fell && !frame_end_i && !srst)
        |=> act_q[$past(wr_ch)] == $past(act_q[wr_ch]))
        else $error("deferred write changed the active code");

    a_load_trigger_n_all: assert property (@(posedge clk_i)
        disable iff (!int_rst_n || !clear_n_i)
        (load_trigger_n_fell && !srst) |=> (act_q == $past(buf_d)) && update_q)
        else $error("trigger edge did not load every channel");

    a_fell_once: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        load_trigger_n_fell |=> !load_trigger_n_fell)
        else $error("trigger copy repeated");

    a_only_update: assert property (@(posedge clk_i)
        disable iff (!int_rst_n || !clear_n_i)
        ($changed(act_q) && !$past(srst)) |-> update_q)
        else $error("active code changed without an update");

    a_soft_reset: assert property (@(posedge clk_i)
        disable iff (!int_rst_n || !clear_n_i)
        soft_rst |=> (act_q == '0) && (buf_q == '0)
            && (pd_q == ocu_pkg::PD_RST) && !update_q)
        else $error("soft reset code did not reset");

    a_gcall_reset: assert property (@(posedge clk_i)
        disable iff (!int_rst_n || !clear_n_i)
        (byte_vld_i && (byte_i == ocu_pkg::GC_RESET_BYTE) && !start_i
            && !stop_i && (u_gcall.state_q == ocu_pkg::GC_ADDRESSED))
        |-> ##2 (buf_q == '0))
        else $error("general call reset not applied");

    a_pd_write: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        (wr_pd && !srst) |=> pd_q == $past(wr_data_i[7:0]))
        else $error("power-down write lost");

    a_code_range: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        bank_legal(buf_q) && bank_legal(act_q))
        else $error("code outside variant range");

endmodule : ocu_update_ctrl
`default_nettype wire

/* File: testbench/ocu_bus_model.sv */
// Purpose: Serial bus master stand-in feeding framed events to the block.
// Assumes: Bus conditions are already decoded to one-cycle pulses.
// Notes:   Released data lines show the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
module ocu_bus_model (
    // Clock
    input  wire logic                       clk_i,
    // Bus events
    output var  logic                       start_o,
    output var  logic                       stop_o,
    output var  logic                       byte_vld_o,
    output var  logic [7:0]                 byte_o,
    output var  logic                       frame_end_o,
    // Register writes
    output var  logic                       wr_o,
    output var  logic [ocu_pkg::ADDR_W-1:0] wr_addr_o,
    output var  logic [ocu_pkg::DATA_W-1:0] wr_data_o,
    // Trigger pin
    output var  logic                       load_trigger_n_o
);
    // ********************
    // Idle levels
    // ********************
    initial begin
        start_o          = 1'b0;
        stop_o           = 1'b0;
        byte_vld_o       = 1'b0;
        byte_o           = 8'h5a;
        frame_end_o      = 1'b0;
        wr_o             = 1'b0;
        wr_addr_o        = 4'h0;
        wr_data_o        = 16'h0000;
        load_trigger_n_o = 1'b1;
    end

    // ********************
    // Transfers
    // ********************
    // One write frame; gap idles before the stop to act slowly
    task automatic frame_write(input logic [3:0] a, input logic [15:0] d,
                               input int gap);
        @(posedge clk_i);
        start_o <= 1'b1;
        @(posedge clk_i);
        start_o   <= 1'b0;
        wr_o      <= 1'b1;
        wr_addr_o <= a;
        wr_data_o <= d;
        @(posedge clk_i);
        wr_o      <= 1'b0;
        wr_addr_o <= ~a;
        wr_data_o <= ~d;
        repeat (gap) @(posedge clk_i);
        stop_o      <= 1'b1;
        frame_end_o <= 1'b1;
        @(posedge clk_i);
        stop_o      <= 1'b0;
        frame_end_o <= 1'b0;
    endtask : frame_write

    // One received byte, valid for a single cycle
    task automatic send_byte(input logic [7:0] b);
        @(posedge clk_i);
        byte_vld_o <= 1'b1;
        byte_o     <= b;
        @(posedge clk_i);
        byte_vld_o <= 1'b0;
        byte_o     <= ~b;
    endtask : send_byte

    // Start, reset call bytes in order, then stop
    task automatic general_call();
        @(posedge clk_i);
        start_o <= 1'b1;
        @(posedge clk_i);
        start_o <= 1'b0;
        send_byte(ocu_pkg::GC_ADDR_BYTE);
        send_byte(ocu_pkg::GC_RESET_BYTE);
        stop_o <= 1'b1;
        @(posedge clk_i);
        stop_o <= 1'b0;
    endtask : general_call

    // Trigger level; a low level selects the copy at frame end, a fall loads all
    task automatic set_trigger(input logic lvl);
        @(posedge clk_i);
        load_trigger_n_o <= lvl;
    endtask : set_trigger
endmodule : ocu_bus_model
`default_nettype wire

/* File: testbench/ocu_update_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the octal code update block.
// Assumes: Wide variant checked in full, narrow buffer spot-checked; the bus model supplies all framed events.
// Notes:   Expected codes live in exp_buf and exp_act.
`timescale 1ns/1ps
`default_nettype none
module ocu_update_ctrl_tb_top;
    // ********************
    // Signals
    // ********************
    logic                                            clk_i, rst_n_i;
    logic                                            clear_n, trig_n;
    logic                                            start, stop, bvld;
    logic                                            fend, wr, upd;
    logic [7:0]                                      bval;
    logic [ocu_pkg::ADDR_W-1:0]                      waddr;
    logic [ocu_pkg::DATA_W-1:0]                      wdata;
    logic [ocu_pkg::NUM_CH-1:0][ocu_pkg::CODE_W-1:0] act, bufc, nbuf;
    logic [ocu_pkg::NUM_CH-1:0]                      pd;
    logic [ocu_pkg::CODE_W-1:0]                      exp_buf[8], exp_act[8];
    logic [7:0]                                      exp_pd;
    int                                              bad_count = 0;
    int                                              check_count = 0;
    bit                                              got;

    // Clock at 200 MHz
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    ocu_bus_model u_bus (.clk_i(clk_i), .start_o(start), .stop_o(stop),
        .byte_vld_o(bvld), .byte_o(bval), .frame_end_o(fend), .wr_o(wr),
        .wr_addr_o(waddr), .wr_data_o(wdata), .load_trigger_n_o(trig_n));

    ocu_update_ctrl #(.WIDE_VARIANT(1'b1)) u_dut (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .load_trigger_n_i(trig_n), .clear_n_i(clear_n),
        .start_i(start), .stop_i(stop), .byte_vld_i(bvld), .byte_i(bval),
        .frame_end_i(fend), .wr_i(wr), .wr_addr_i(waddr), .wr_data_i(wdata),
        .active_code_o(act), .buffer_code_o(bufc), .power_down_o(pd),
        .update_o(upd));

    ocu_update_ctrl #(.WIDE_VARIANT(1'b0)) u_narrow (.clk_i(clk_i),
        .rst_n_i(rst_n_i), .load_trigger_n_i(trig_n), .clear_n_i(clear_n),
        .start_i(start), .stop_i(stop), .byte_vld_i(bvld), .byte_i(bval),
        .frame_end_i(fend), .wr_i(wr), .wr_addr_i(waddr), .wr_data_i(wdata),
        .active_code_o(), .buffer_code_o(nbuf), .power_down_o(),
        .update_o());

    // ********************
    // Helpers
    // ********************
    task automatic check(input string what, input logic [79:0] seen,
                         input logic [79:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // Every channel's buffer and active code, plus power-down
    task automatic check_all();
        for (int c = 0; c < 8; c++) begin
            check("buffer", bufc[c], exp_buf[c]);
            check("active", act[c], exp_act[c]);
        end
        check("power_down", pd, exp_pd);
    endtask : check_all

    task automatic set_codes(input logic [9:0] v);
        for (int c = 0; c < 8; c++) begin
            exp_buf[c] = v;
            exp_act[c] = v;
        end
    endtask : set_codes

    // Bounded look for the one-cycle update pulse
    task automatic wait_upd(input int lim, output bit seen);
        seen = 1'b0;
        repeat (lim) begin
            @(negedge clk_i);
            if (upd === 1'b1) begin
                seen = 1'b1;
                break;
            end
        end
    endtask : wait_upd

    // ********************
    // Scenarios
    // ********************
    task automatic t_reset();
        repeat (16) @(posedge clk_i);
        rst_n_i <= 1'b1;
        repeat (4) @(negedge clk_i);
        set_codes(10'h000);
        exp_pd = 8'hff;
        check_all();
        check("update", upd, 1'b0);
        u_bus.frame_write(ocu_pkg::PD_ADDR, 16'h0000, 0);
        @(negedge clk_i);
        exp_pd = 8'h00;
        check_all();
    endtask : t_reset

    // Trigger low: copy at frame end, fast and slow frames
    task automatic t_immediate();
        u_bus.set_trigger(1'b0);
        repeat (8) @(posedge clk_i);
        u_bus.frame_write(4'hb, 16'h03ff, 0);
        wait_upd(4, got);
        check("update", got, 1'b1);
        exp_buf[3] = 10'h3ff;
        exp_act[3] = 10'h3ff;
        check_all();
        check("narrow", nbuf[3], 10'h0ff);
        u_bus.frame_write(4'h8, 16'hfd55, 5);
        wait_upd(6, got);
        check("update", got, 1'b1);
        exp_buf[0] = 10'h155;
        exp_act[0] = 10'h155;
        check_all();
    endtask : t_immediate

    // Trigger high: buffers only, then one fall loads all
    task automatic t_deferred();
        u_bus.set_trigger(1'b1);
        repeat (4) @(posedge clk_i);
        for (int c = 0; c < 8; c++) begin
            u_bus.frame_write({1'b1, c[2:0]}, {6'h00, c[2:0], 7'h2a}, 0);
            exp_buf[c] = {c[2:0], 7'h2a};
        end
        wait_upd(8, got);
        check("update", got, 1'b0);
        check_all();
        u_bus.set_trigger(1'b0);
        wait_upd(8, got);
        check("update", got, 1'b1);
        for (int c = 0; c < 8; c++) exp_act[c] = exp_buf[c];
        check_all();
        wait_upd(10, got);
        check("update", got, 1'b0);
        u_bus.set_trigger(1'b1);
        repeat (6) @(posedge clk_i);
    endtask : t_deferred

    // Clear lands mid-frame, before the write is taken
    task automatic t_clear();
        fork
            u_bus.frame_write(4'h9, 16'h02aa, 0);
        join_none
        repeat (2) @(posedge clk_i);
        clear_n <= 1'b0;
        #1;
        check("active", act, 80'h0);
        check("buffer", bufc, 80'h0);
        repeat (3) @(posedge clk_i);
        clear_n <= 1'b1;
        wait fork;
        repeat (4) @(negedge clk_i);
        set_codes(10'h000);
        check_all();
    endtask : t_clear

    // Soft reset code or general call reset
    task automatic t_sw_reset(input bit gc);
        u_bus.frame_write(4'hd, 16'h0123, 0);
        @(negedge clk_i);
        exp_buf[5] = 10'h123;
        check_all();
        if (gc) begin
            u_bus.general_call();
        end else begin
            u_bus.frame_write(ocu_pkg::TRIG_ADDR, ocu_pkg::SOFT_RST_CODE, 0);
        end
        repeat (3) @(negedge clk_i);
        set_codes(10'h000);
        exp_pd = 8'hff;
        check_all();
        u_bus.frame_write(ocu_pkg::PD_ADDR, 16'h0000, 0);
        exp_pd = 8'h00;
    endtask : t_sw_reset

    // ********************
    // Run control
    // ********************
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : wrap_up

    // Watchdog: the run needs well under 1000 cycles
    initial begin
        #20000;
        bad_count++;
        wrap_up();
    end

    initial begin
        rst_n_i = 1'b0;
        clear_n = 1'b1;
        t_reset();
        t_immediate();
        t_deferred();
        t_clear();
        t_sw_reset(1'b0);
        t_sw_reset(1'b1);
        wrap_up();
    end
endmodule : ocu_update_ctrl_tb_top
`default_nettype wire
